// File: core/vic_pkg.sv
`default_nettype none
package vic_pkg;

	// apb register byte offsets
	localparam logic [7:0] VIC_OFS_FLAGS0  = 8'h00;
	localparam logic [7:0] VIC_OFS_FLAGS1  = 8'h04;
	localparam logic [7:0] VIC_OFS_FLAGS2  = 8'h08;
	localparam logic [7:0] VIC_OFS_MASK0   = 8'h0c;
	localparam logic [7:0] VIC_OFS_MASK1   = 8'h10;
	localparam logic [7:0] VIC_OFS_MASK2   = 8'h14;
	localparam logic [7:0] VIC_OFS_CLEAR0  = 8'h18;
	localparam logic [7:0] VIC_OFS_CLEAR1  = 8'h1c;
	localparam logic [7:0] VIC_OFS_CLEAR2  = 8'h20;
	localparam logic [7:0] VIC_OFS_CONTROL = 8'h24;
	localparam logic [7:0] VIC_OFS_FIXVEC  = 8'h28;
	localparam logic [7:0] VIC_OFS_MODVEC  = 8'h2c;
	localparam logic [7:0] VIC_OFS_STATUS  = 8'h30;

	// source layout: serial 0..7, dma 8..15, timers 16..19
	localparam int VIC_NSRC      = 20;
	localparam int VIC_SER_LO    = 0;
	localparam int VIC_DMA_LO    = 8;
	localparam int VIC_TMR_LO    = 16;
	localparam int VIC_GRP_W     = 8;
	localparam int VIC_TMR_W     = 4;

	// control register fields
	localparam int VIC_CTL_ACK_LSB = 0;
	localparam int VIC_CTL_VSEL    = 2;
	localparam int VIC_CTL_SWAP    = 3;
	localparam int VIC_CODE_W      = 6;

	// reset values
	localparam logic [3:0] VIC_CTL_RST    = 4'h0;
	localparam logic [7:0] VIC_FIXVEC_RST = 8'h00;
	localparam logic [1:0] VIC_MODHI_RST  = 2'h0;

	// acknowledge protocols
	localparam logic [1:0] VIC_ACK_NONE   = 2'h0;
	localparam logic [1:0] VIC_ACK_SINGLE = 2'h1;
	localparam logic [1:0] VIC_ACK_DOUBLE = 2'h2;

	typedef struct packed {
		logic       swap;     // dma ahead of serial
		logic       vsel;     // 1 = modified vector
		logic [1:0] ack_type; // protocol
	} vic_ctrl_t;

endpackage : vic_pkg
`default_nettype wire

// File: core/vic_prio.sv
`timescale 1ns/1ps
`default_nettype none
module vic_prio
	import vic_pkg::*;
(
	input  wire logic                  pclk,    // system clock
	input  wire logic                  presetn, // async reset, low
	input  wire logic [VIC_NSRC-1:0]   active,  // unmasked flags
	input  wire logic                  swap,    // dma before serial
	output logic      [VIC_CODE_W-1:0] code     // winner index + 1, 0 = none
);

	// lowest set bit of a field; index+1 so zero can mean none
	function automatic logic [VIC_CODE_W-1:0] first_set(input logic [VIC_NSRC-1:0] v, input int lo, input int w);
		logic [VIC_CODE_W-1:0] r;
		r = '0;
		for (int i = w - 1; i >= 0; i--) begin
			if (v[lo + i]) begin
				r = VIC_CODE_W'(lo + i + 1);
			end
		end
		return r;
	endfunction

	wire logic [VIC_CODE_W-1:0] c_ser = first_set(active, VIC_SER_LO, VIC_GRP_W);
	wire logic [VIC_CODE_W-1:0] c_dma = first_set(active, VIC_DMA_LO, VIC_GRP_W);
	wire logic [VIC_CODE_W-1:0] c_tmr = first_set(active, VIC_TMR_LO, VIC_TMR_W);
	wire logic [VIC_CODE_W-1:0] c_hi  = swap ? c_dma : c_ser;
	wire logic [VIC_CODE_W-1:0] c_mid = swap ? c_ser : c_dma;

	// timers always last; group order set by the swap bit
	assign code = (c_hi != '0) ? c_hi : (c_mid != '0) ? c_mid : c_tmr;

	property p_serial_wins;
		@(posedge pclk) disable iff (!presetn)
		(!swap && active[VIC_DMA_LO-1:VIC_SER_LO] != '0) |-> (code >= 6'h01 && code <= 6'h08);
	endproperty
	a_serial_wins: assert property (p_serial_wins) else $error("serial source lost priority");

	property p_dma_wins;
		@(posedge pclk) disable iff (!presetn)
		(swap && active[VIC_TMR_LO-1:VIC_DMA_LO] != '0) |-> (code >= 6'h09 && code <= 6'h10);
	endproperty
	a_dma_wins: assert property (p_dma_wins) else $error("swap did not favour dma");

endmodule : vic_prio
`default_nettype wire

// File: core/vic_ackseq.sv
`timescale 1ns/1ps
`default_nettype none
module vic_ackseq
	import vic_pkg::*;
(
	input  wire logic       pclk,     // system clock
	input  wire logic       presetn,  // async reset, low
	input  wire logic       ack_low,  // synchronised acknowledge level
	input  wire logic       ack_fall, // acknowledge just went low
	input  wire logic [1:0] ack_type, // protocol select
	output logic            capture,  // latch vector now
	output logic            drive,    // vector on the bus
	output logic            busy      // cycle in progress
);

	typedef enum logic [1:0] {ACK_IDLE, ACK_FIRST, ACK_WAIT2, ACK_SECOND} vic_ack_t;
	vic_ack_t state;
	vic_ack_t next_state;

	wire logic single = (ack_type == VIC_ACK_SINGLE);
	wire logic dbl    = (ack_type == VIC_ACK_DOUBLE);

	// next state; the reserved code behaves like non-acknowledge
	always_comb begin
		next_state = state;
		unique case (state)
			ACK_IDLE:   if (ack_fall) next_state = ACK_FIRST;
			ACK_FIRST:  if (!ack_low) next_state = dbl ? ACK_WAIT2 : ACK_IDLE;
			ACK_WAIT2:  if (ack_fall) next_state = ACK_SECOND;
			ACK_SECOND: if (!ack_low) next_state = ACK_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) state <= ACK_IDLE;
		else          state <= next_state;
	end

	// vector only in the assertion the protocol names; gated by the live level so the
	// bus is let go in the cycle the host releases acknowledge, not one cycle later
	assign capture = ack_fall && ((state == ACK_IDLE && single) || (state == ACK_WAIT2 && dbl));
	assign drive   = ack_low && ((state == ACK_FIRST && single) || (state == ACK_SECOND && dbl));
	assign busy    = (state != ACK_IDLE);

	property p_double_first_silent;
		@(posedge pclk) disable iff (!presetn)
		(state == ACK_FIRST && dbl) |-> !drive;
	endproperty
	a_double_first_silent: assert property (p_double_first_silent) else $error("vector on first ack in double mode");

endmodule : vic_ackseq
`default_nettype wire

// File: core/vic_top.sv
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module vic_top
	import vic_pkg::*;
(
	input  wire logic                pclk,       // system clock, 10 MHz
	input  wire logic                presetn,    // async reset, low
	input  wire logic                psel,       // apb select
	input  wire logic                penable,    // apb access phase
	input  wire logic                pwrite,     // apb write
	input  wire logic [7:0]          paddr,      // apb byte address
	input  wire logic [31:0]         pwdata,     // apb write data
	output logic      [31:0]         prdata,     // apb read data
	output logic                     pready,     // apb ready
	output logic                     pslverr,    // apb error, unmapped
	input  wire logic [VIC_NSRC-1:0] src_evt,    // source event pulses
	output logic                     irq_n_out,  // request pin level when driven
	output logic                     irq_n_oe_n, // request pin enable, low drives
	input  wire logic                irq_ack_n,  // acknowledge pin, low
	output logic      [7:0]          vec_out,    // vector bus data
	output logic                     vec_oe_n    // vector bus enable, low drives
);

	////////////////////////////////////////////////////////////////////////
	// register state

	logic [VIC_NSRC-1:0]   flags;
	logic [VIC_NSRC-1:0]   mask;
	vic_ctrl_t             ctrl;
	logic [7:0]            fixed_vec;
	logic [1:0]            mod_hi;
	logic [VIC_CODE_W-1:0] hw_code;
	logic                  irq_drive;
	logic [2:0]            ack_sync;
	logic                  ack_fall;
	logic                  seq_capture;
	logic                  seq_drive;
	logic                  seq_busy;
	logic [VIC_CODE_W-1:0] win_code;

	////////////////////////////////////////////////////////////////////////
	// apb decode

	wire logic wr_en  = psel && penable && pwrite;
	wire logic rd_set = psel && !penable && !pwrite;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	wire logic mapped = hit(paddr, VIC_OFS_FLAGS0) || hit(paddr, VIC_OFS_FLAGS1) || hit(paddr, VIC_OFS_FLAGS2)
		|| hit(paddr, VIC_OFS_MASK0) || hit(paddr, VIC_OFS_MASK1) || hit(paddr, VIC_OFS_MASK2)
		|| hit(paddr, VIC_OFS_CLEAR0) || hit(paddr, VIC_OFS_CLEAR1) || hit(paddr, VIC_OFS_CLEAR2)
		|| hit(paddr, VIC_OFS_CONTROL) || hit(paddr, VIC_OFS_FIXVEC) || hit(paddr, VIC_OFS_MODVEC)
		|| hit(paddr, VIC_OFS_STATUS);

	// zero-wait slave; error only on an unmapped address
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// write-one clear strobes, spread over the three flag groups
	wire logic [VIC_NSRC-1:0] clr = wr_en ? {
		hit(paddr, VIC_OFS_CLEAR2) ? pwdata[VIC_TMR_W-1:0] : 4'h0,
		hit(paddr, VIC_OFS_CLEAR1) ? pwdata[VIC_GRP_W-1:0] : 8'h00,
		hit(paddr, VIC_OFS_CLEAR0) ? pwdata[VIC_GRP_W-1:0] : 8'h00} : '0;

	wire logic [VIC_NSRC-1:0] mask_wr = wr_en ? {
		hit(paddr, VIC_OFS_MASK2) ? {4{1'b1}} : 4'h0,
		hit(paddr, VIC_OFS_MASK1) ? {8{1'b1}} : 8'h00,
		hit(paddr, VIC_OFS_MASK0) ? {8{1'b1}} : 8'h00} : '0;

	wire logic [VIC_NSRC-1:0] mask_data = {pwdata[VIC_TMR_W-1:0], pwdata[VIC_GRP_W-1:0], pwdata[VIC_GRP_W-1:0]};

	////////////////////////////////////////////////////////////////////////
	// source flags: an event in the clearing cycle survives

	wire logic [VIC_NSRC-1:0] next_flags = (flags & ~clr) | src_evt;
	wire logic [VIC_NSRC-1:0] next_mask  = (mask & ~mask_wr) | (mask_data & mask_wr);
	wire logic [VIC_NSRC-1:0] active     = flags & mask;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0;
			mask  <= '0;
		end else begin
			flags <= next_flags;
			mask  <= next_mask;
		end
	end

	// control, fixed vector and soft half of the modified vector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl      <= vic_ctrl_t'(VIC_CTL_RST);
			fixed_vec <= VIC_FIXVEC_RST;
			mod_hi    <= VIC_MODHI_RST;
		end else if (wr_en) begin
			if (hit(paddr, VIC_OFS_CONTROL)) ctrl <= vic_ctrl_t'(pwdata[VIC_CTL_SWAP:VIC_CTL_ACK_LSB]);
			if (hit(paddr, VIC_OFS_FIXVEC)) fixed_vec <= pwdata[7:0];
			if (hit(paddr, VIC_OFS_MODVEC)) mod_hi <= pwdata[7:6];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// priority and the hardware half of the modified vector

	vic_prio u_prio (
		.pclk    (pclk),
		.presetn (presetn),
		.active  (active),
		.swap    (ctrl.swap),
		.code    (win_code)
	);

	// registered so the vector field cannot glitch mid-read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hw_code <= '0;
		else          hw_code <= win_code;
	end

	wire logic [7:0] mod_vec = {mod_hi, hw_code};

	////////////////////////////////////////////////////////////////////////
	// request pin: pulled low while anything unmasked is pending

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) irq_drive <= 1'b0;
		else          irq_drive <= |active;
	end

	assign irq_n_out  = 1'b0;       // open drain: only ever pulls low
	assign irq_n_oe_n = !irq_drive; // released means external pull-up

	////////////////////////////////////////////////////////////////////////
	// acknowledge pin: two-flop sync, third stage only for the edge

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ack_sync <= 3'h7;
		else          ack_sync <= {ack_sync[1:0], irq_ack_n};
	end

	wire logic ack_low = !ack_sync[1];
	assign ack_fall = !ack_sync[1] && ack_sync[2];

	vic_ackseq u_ackseq (
		.pclk     (pclk),
		.presetn  (presetn),
		.ack_low  (ack_low),
		.ack_fall (ack_fall),
		.ack_type (ctrl.ack_type),
		.capture  (seq_capture),
		.drive    (seq_drive),
		.busy     (seq_busy)
	);

	// vector frozen at the start of the driven assertion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)         vec_out <= 8'h00;
		else if (seq_capture) vec_out <= ctrl.vsel ? mod_vec : fixed_vec;
	end

	assign vec_oe_n = !seq_drive;

	////////////////////////////////////////////////////////////////////////
	// read data, captured in the setup phase

	wire logic [31:0] rd_mux =
		hit(paddr, VIC_OFS_FLAGS0)  ? {24'h000000, flags[VIC_DMA_LO-1:VIC_SER_LO]} :
		hit(paddr, VIC_OFS_FLAGS1)  ? {24'h000000, flags[VIC_TMR_LO-1:VIC_DMA_LO]} :
		hit(paddr, VIC_OFS_FLAGS2)  ? {28'h0000000, flags[VIC_NSRC-1:VIC_TMR_LO]} :
		hit(paddr, VIC_OFS_MASK0)   ? {24'h000000, mask[VIC_DMA_LO-1:VIC_SER_LO]} :
		hit(paddr, VIC_OFS_MASK1)   ? {24'h000000, mask[VIC_TMR_LO-1:VIC_DMA_LO]} :
		hit(paddr, VIC_OFS_MASK2)   ? {28'h0000000, mask[VIC_NSRC-1:VIC_TMR_LO]} :
		hit(paddr, VIC_OFS_CONTROL) ? {28'h0000000, ctrl} :
		hit(paddr, VIC_OFS_FIXVEC)  ? {24'h000000, fixed_vec} :
		hit(paddr, VIC_OFS_MODVEC)  ? {24'h000000, mod_vec} :
		hit(paddr, VIC_OFS_STATUS)  ? {29'h0, seq_drive, seq_busy, irq_drive} :
		32'h00000000; // clear registers and holes read zero

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)    prdata <= 32'h00000000;
		else if (rd_set) prdata <= rd_mux;
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_flag_set;
		@(posedge pclk) disable iff (!presetn)
		(src_evt != '0) |=> ((flags & $past(src_evt)) == $past(src_evt));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("source event did not set its flag");

	property p_masked_quiet;
		@(posedge pclk) disable iff (!presetn)
		(active == '0) [*2] |-> irq_n_oe_n;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("request with nothing unmasked");

	property p_request;
		@(posedge pclk) disable iff (!presetn)
		(active != '0) |=> !irq_n_oe_n;
	endproperty
	a_request: assert property (p_request) else $error("unmasked flag gave no request");

	property p_release;
		@(posedge pclk) disable iff (!presetn)
		$rose(irq_n_oe_n) |-> ($past(active) == '0);
	endproperty
	a_release: assert property (p_release) else $error("request dropped while source pending");

	property p_open_drain;
		@(posedge pclk) disable iff (!presetn)
		irq_n_out == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("request pin driven high");

	property p_none_silent;
		@(posedge pclk) disable iff (!presetn)
		(ctrl.ack_type != VIC_ACK_SINGLE && ctrl.ack_type != VIC_ACK_DOUBLE) [*3] |-> vec_oe_n;
	endproperty
	a_none_silent: assert property (p_none_silent) else $error("vector driven in non-acknowledge mode");

	property p_single_drive;
		@(posedge pclk) disable iff (!presetn)
		(ctrl.ack_type == VIC_ACK_SINGLE && !seq_busy && $fell(ack_sync[1])) |=> (!vec_oe_n throughout ack_low [*1]);
	endproperty
	a_single_drive: assert property (p_single_drive) else $error("single mode missed first ack");

	property p_ack_on_low;
		@(posedge pclk) disable iff (!presetn)
		!vec_oe_n |-> ack_low;
	endproperty
	a_ack_on_low: assert property (p_ack_on_low) else $error("vector driven while ack high");

	property p_fixed_vec;
		@(posedge pclk) disable iff (!presetn)
		(seq_capture && !ctrl.vsel) |=> (vec_out == $past(fixed_vec));
	endproperty
	a_fixed_vec: assert property (p_fixed_vec) else $error("fixed vector altered");

	property p_mod_vec;
		@(posedge pclk) disable iff (!presetn)
		(seq_capture && ctrl.vsel) |=> (vec_out == {$past(mod_hi), $past(hw_code)});
	endproperty
	a_mod_vec: assert property (p_mod_vec) else $error("modified vector wrong");

	property p_code_track;
		@(posedge pclk) disable iff (!presetn)
		(win_code != '0) |=> (hw_code == $past(win_code));
	endproperty
	a_code_track: assert property (p_code_track) else $error("source code not tracked");

	property p_clear_flag;
		@(posedge pclk) disable iff (!presetn)
		(clr != '0) |=> ((flags & $past(clr & ~src_evt)) == '0);
	endproperty
	a_clear_flag: assert property (p_clear_flag) else $error("cleared flag still set");

	property p_timer_last;
		@(posedge pclk) disable iff (!presetn)
		(active[VIC_TMR_LO-1:0] != '0) |-> (win_code != '0 && win_code <= 6'h10);
	endproperty
	a_timer_last: assert property (p_timer_last) else $error("timer source beat serial or dma");

	property p_no_code;
		@(posedge pclk) disable iff (!presetn)
		(active == '0) |-> (win_code == '0);
	endproperty
	a_no_code: assert property (p_no_code) else $error("source code with nothing unmasked");

	property p_vec_hold;
		@(posedge pclk) disable iff (!presetn)
		(!vec_oe_n && !$past(vec_oe_n)) |-> $stable(vec_out);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector changed while driven");

	c_single: cover property (@(posedge pclk) disable iff (!presetn) seq_capture && ctrl.ack_type == VIC_ACK_SINGLE);
	c_double: cover property (@(posedge pclk) disable iff (!presetn) seq_capture && ctrl.ack_type == VIC_ACK_DOUBLE);
	c_clear_race: cover property (@(posedge pclk) disable iff (!presetn) (clr & src_evt) != '0);
	c_release: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_n_oe_n));

endmodule : vic_top
`default_nettype wire

// File: test/vic_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vic_host_model (
	input  wire logic       pclk,     // system clock
	input  wire logic       irq_n,    // request wire after pull-up
	input  wire logic [7:0] vec_out,  // vector bus data
	input  wire logic       vec_oe_n, // vector bus enable, low drives
	output logic            irq_ack_n // acknowledge pin, low
);
	logic [7:0] last_vec;
	wire  [7:0] vec_bus;

	////////////////////////////////////////
	// a released bus shows the inverse of its last value, so a stale vector never matches
	assign vec_bus = vec_oe_n ? ~last_vec : vec_out;

	// remember what was last driven
	initial last_vec = 8'h00;
	always @(posedge pclk) begin
		if (vec_oe_n === 1'b0) last_vec <= vec_out;
	end

	initial irq_ack_n = 1'b1;

	////////////////////////////////////////
	// n acknowledge pulses of len low cycles each; reports the pulse that carried a vector
	task automatic ack_cycle(input int n, input int len, output int hit, output logic [7:0] vec);
		int k;
		int c;
		hit = 0;
		vec = 8'h00;
		while (irq_n !== 1'b0) begin
			@(posedge pclk);
		end
		for (k = 1; k <= n; k++) begin
			irq_ack_n <= 1'b0;
			for (c = 0; c < len + 6; c++) begin
				@(posedge pclk);
				if (c == len - 1) irq_ack_n <= 1'b1;
				if (vec_oe_n === 1'b0 && hit == 0) begin
					hit = k;
					vec = vec_bus;
				end
			end
		end
	endtask
endmodule // vic_host_model
`default_nettype wire

// File: test/tb_vectored_interrupt_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_interrupt_controller
	import vic_pkg::*;
;
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]          paddr, vec_out;
	logic [31:0]         pwdata, prdata, rd;
	logic [VIC_NSRC-1:0] src_evt;
	logic                irq_n_out, irq_n_oe_n, irq_ack_n, vec_oe_n, err;
	wire                 irq_n;
	int                  fail_count, total_checks, cycles;

	// pull-up on the open-drain request wire
	assign irq_n = irq_n_oe_n ? 1'b1 : irq_n_out;

	vic_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.src_evt(src_evt), .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n), .irq_ack_n(irq_ack_n),
		.vec_out(vec_out), .vec_oe_n(vec_oe_n));
	vic_host_model i_host (.pclk(pclk), .irq_n(irq_n), .vec_out(vec_out), .vec_oe_n(vec_oe_n),
		.irq_ack_n(irq_ack_n));

	initial pclk = 1'b0;
	always #50 pclk = ~pclk;

	// hang guard, far above the expected run length
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			give_verdict();
		end
	end

	////////////////////////////////////////
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic pulse(input logic [19:0] p);
		src_evt <= p;
		@(posedge pclk);
		src_evt <= '0;
		repeat (3) @(posedge pclk);
	endtask

	// serial and dma swap ranks under the swap bit; timers always last, low index first
	function automatic logic [5:0] exp_code(input logic [19:0] act, input logic sw);
		logic [5:0] c;
		int i;
		int r;
		int best;
		c = 6'h00;
		best = 3;
		for (i = VIC_NSRC - 1; i >= 0; i--) begin
			r = (i >= VIC_TMR_LO) ? 2 : (((i >= VIC_DMA_LO) ^ sw) ? 1 : 0);
			if (act[i] && r <= best) begin
				c = 6'(i + 1);
				best = r;
			end
		end
		return c;
	endfunction

	////////////////////////////////////////
	initial begin
		int i, g, k, t, v, hit, eh;
		logic [19:0] m, p;
		logic sw;
		logic [1:0] hi;
		logic [7:0] fv, vec;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		src_evt = '0;
		fail_count = 0;
		total_checks = 0;
		cycles = 0;
		void'($urandom(32'hf456b875));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset values, then the unmapped word just past the map
		chk({irq_n, vec_oe_n}, 2'b11);
		for (i = 0; i <= 13; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, 32'h0);
			chk(err, (i == 13));
		end
		apb(1'b1, VIC_OFS_FLAGS0, 32'hff);
		apb(1'b0, VIC_OFS_FLAGS0, 32'h0);
		chk(rd, 32'h0);
		$display("test reset_map done");
		// every source on its own: masked, enabled, cleared
		for (i = 0; i < VIC_NSRC; i++) begin
			g = i / 8;
			pulse(20'(1) << i);
			chk(irq_n, 1'b1);
			apb(1'b0, 8'(VIC_OFS_FLAGS0 + 4 * g), 32'h0);
			chk(rd, 32'(1) << (i % 8));
			apb(1'b1, 8'(VIC_OFS_MASK0 + 4 * g), 32'(1) << (i % 8));
			apb(1'b0, 8'(VIC_OFS_MASK0 + 4 * g), 32'h0);
			chk(rd, 32'(1) << (i % 8));
			repeat (2) @(posedge pclk);
			chk(irq_n, 1'b0);
			apb(1'b0, VIC_OFS_STATUS, 32'h0);
			chk(rd, 32'h1);
			apb(1'b0, VIC_OFS_MODVEC, 32'h0);
			chk(rd[5:0], 6'(i + 1));
			apb(1'b1, 8'(VIC_OFS_CLEAR0 + 4 * g), 32'(1) << (i % 8));
			repeat (2) @(posedge pclk);
			chk(irq_n, 1'b1);
			apb(1'b0, 8'(VIC_OFS_FLAGS0 + 4 * g), 32'h0);
			chk(rd, 32'h0);
			apb(1'b1, 8'(VIC_OFS_MASK0 + 4 * g), 32'h0);
		end
		$display("test single_sources done");
		// random mixes under random masks; first two are serial against dma, both swaps
		for (k = 0; k < 40; k++) begin
			m = (k < 2) ? 20'hfffff : 20'($urandom);
			p = (k < 2) ? 20'hff0f0 : 20'($urandom);
			sw = (k < 2) ? k[0] : 1'($urandom);
			hi = 2'($urandom);
			for (g = 0; g < 3; g++) apb(1'b1, 8'(VIC_OFS_MASK0 + 4 * g), 32'(m >> (8 * g)) & 32'hff);
			apb(1'b1, VIC_OFS_CONTROL, {28'h0, sw, 1'b1, 2'b00});
			apb(1'b1, VIC_OFS_MODVEC, {24'h0, hi, 6'h00});
			pulse(p);
			chk(irq_n, ~|(p & m));
			apb(1'b0, VIC_OFS_MODVEC, 32'h0);
			chk(rd, {24'h0, hi, exp_code(p & m, sw)});
			for (g = 0; g < 3; g++) apb(1'b1, 8'(VIC_OFS_CLEAR0 + 4 * g), 32'hff);
		end
		$display("test priority done");
		// every acknowledge protocol with both vector sources
		apb(1'b1, VIC_OFS_MASK0, 32'h20);
		for (t = 0; t < 4; t++) begin
			for (v = 0; v < 2; v++) begin
				fv = 8'($urandom);
				hi = 2'($urandom);
				apb(1'b1, VIC_OFS_FIXVEC, {24'h0, fv});
				apb(1'b0, VIC_OFS_FIXVEC, 32'h0);
				chk(rd, {24'h0, fv});
				apb(1'b1, VIC_OFS_MODVEC, {24'h0, hi, 6'h00});
				apb(1'b1, VIC_OFS_CONTROL, 32'(v * 4 + t));
				apb(1'b0, VIC_OFS_CONTROL, 32'h0);
				chk(rd, 32'(v * 4 + t));
				pulse(20'h00020);
				i_host.ack_cycle(2, 4 + int'($urandom % 6), hit, vec);
				eh = (t == 1) ? 1 : ((t == 2) ? 2 : 0);
				chk(32'(hit), 32'(eh));
				if (eh != 0) chk(vec, v ? {hi, 6'h06} : fv);
				apb(1'b1, VIC_OFS_CLEAR0, 32'h20);
				repeat (4) @(posedge pclk);
			end
		end
		$display("test acknowledge done");
		give_verdict();
	end
endmodule // tb_vectored_interrupt_controller
`default_nettype wire
